// [core/oag_pkg.sv]
// Constants, encodings and state type for the operand address generator.
package oag_pkg;
    localparam logic [15:0] RESET_PC     = 16'h0000;
    localparam logic [15:0] RESET_WP     = 16'h0080;
    localparam logic [15:0] WORD_STEP    = 16'h0002;
    localparam logic [15:0] BYTE_STEP    = 16'h0001;
    localparam logic [15:0] LINK_OFFSET  = 16'h0016;
    localparam logic [3:0]  LINK_REG     = 4'hb;
    // Operand address modes.
    localparam logic [1:0]  MODE_REG     = 2'h0;
    localparam logic [1:0]  MODE_IND     = 2'h1;
    localparam logic [1:0]  MODE_SYM     = 2'h2;
    localparam logic [1:0]  MODE_AUTO    = 2'h3;
    // Major opcodes in instruction bits 15:12.
    localparam logic [3:0]  OP_SINGLE    = 4'h0;
    localparam logic [3:0]  OP_JUMP      = 4'h1;
    localparam logic [3:0]  OP_SET_ZEROS = 4'h4;
    localparam logic [3:0]  OP_SUB_BYTE  = 4'h5;
    localparam logic [3:0]  OP_CMP_BYTE  = 4'h6;
    localparam logic [3:0]  OP_ADD       = 4'h7;
    localparam logic [3:0]  OP_MOVE      = 4'h8;
    // Single operand sub-codes in bits 11:8.
    localparam logic [3:0]  SUB_LINK     = 4'h0;
    localparam logic [3:0]  SUB_DECR     = 4'h1;
    localparam logic [3:0]  SUB_ZERO     = 4'h2;
    // Jump conditions in bits 11:8.
    localparam logic [3:0]  JC_ALWAYS    = 4'h0;
    localparam logic [3:0]  JC_NE        = 4'h1;
    localparam logic [3:0]  JC_ODD       = 4'h2;
    localparam logic [3:0]  JC_CARRY     = 4'h3;
    typedef enum logic [3:0] {
        S_FETCH  = 4'h0,
        S_DECODE = 4'h1,
        S_START  = 4'h3,
        S_EXT    = 4'h2,
        S_REG    = 4'h6,
        S_ADDR   = 4'h7,
        S_OPRD   = 4'h5,
        S_INC    = 4'h4,
        S_WRITE  = 4'hc,
        S_DINC   = 4'hd,
        S_LINK   = 4'hf
    } oag_state_type;
endpackage

// [core/oag_ea_unit.sv]
// Effective address, register address, increment and jump target arithmetic.
`timescale 1ns/10ps
module oag_ea_unit (
    input  wire logic [1:0]  mode,
    input  wire logic [3:0]  rnum,
    input  wire logic        is_byte,
    input  wire logic [15:0] wp,
    input  wire logic [15:0] rv,
    input  wire logic [15:0] ext,
    input  wire logic [15:0] pc,
    input  wire logic [7:0]  disp,
    output logic      [15:0] ea,
    output logic      [15:0] reg_addr,
    output logic      [15:0] inc_val,
    output logic      [15:0] jump_target
);
    always_comb begin
        reg_addr    = {wp[15:1], 1'b0} + {11'h000, rnum, 1'b0};
        inc_val     = rv + (is_byte ? oag_pkg::BYTE_STEP
                                    : oag_pkg::WORD_STEP);
        jump_target = pc + {{7{disp[7]}}, disp, 1'b0};
        if (mode == oag_pkg::MODE_REG) begin
            ea = reg_addr;
        end else if (mode == oag_pkg::MODE_SYM) begin
            ea = ext + ((rnum != 4'h0) ? rv : 16'h0000);
        end else begin
            ea = rv;
        end
    end
endmodule

// [core/oag_core.sv]
// Instruction sequencer with operand address generation over a memory port.
`timescale 1ns/10ps
module oag_core (
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic        wp_set,
    input  wire logic [15:0] wp_data,
    output logic             mem_req,
    output logic             mem_we,
    output logic      [15:0] mem_addr,
    output logic      [15:0] mem_wdata,
    output logic      [1:0]  mem_be,
    input  wire logic        mem_ack,
    input  wire logic [15:0] mem_rdata,
    output logic      [15:0] pc,
    output logic      [15:0] wp,
    output logic             status_eq,
    output logic             status_carry,
    output logic             status_odd
);
    oag_pkg::oag_state_type state_reg, state_next;
    logic [15:0] pc_reg, pc_next, wp_reg, wp_next, ir_reg, ir_next;
    logic [15:0] ext_reg, ext_next, rv_reg, rv_next, ea_reg, ea_next;
    logic [15:0] src_reg, src_next, dst_reg, dst_next;
    logic        phase_reg, phase_next;
    logic        eq_reg, eq_next, cy_reg, cy_next, odd_reg, odd_next;
    logic [3:0]  opc, sub, rnum;
    logic [1:0]  mode;
    logic        single, is_byte, use_dst, taken, known;
    logic [15:0] ea_calc, reg_addr, inc_val, jtarget, res, byte_in;
    logic [16:0] wide;
    logic        res_cy;

    assign opc     = ir_reg[15:12];
    assign sub     = ir_reg[11:8];
    assign single  = (opc == oag_pkg::OP_SINGLE);
    assign is_byte = (opc == oag_pkg::OP_SUB_BYTE) ||
                     (opc == oag_pkg::OP_CMP_BYTE);
    assign use_dst = phase_reg && !single;
    assign mode    = use_dst ? ir_reg[11:10] : ir_reg[5:4];
    assign rnum    = use_dst ? ir_reg[9:6] : ir_reg[3:0];
    assign known   = single ? (sub <= oag_pkg::SUB_ZERO)
                            : (opc >= oag_pkg::OP_SET_ZEROS &&
                               opc <= oag_pkg::OP_MOVE);
    assign byte_in = ea_reg[0] ? {mem_rdata[7:0], 8'h00}
                               : {mem_rdata[15:8], 8'h00};

    oag_ea_unit u_ea (
        .mode        (mode),
        .rnum        (rnum),
        .is_byte     (is_byte),
        .wp          (wp_reg),
        .rv          (rv_reg),
        .ext         (ext_reg),
        .pc          (pc_reg),
        .disp        (ir_reg[7:0]),
        .ea          (ea_calc),
        .reg_addr    (reg_addr),
        .inc_val     (inc_val),
        .jump_target (jtarget)
    );

    // Jump condition decode.
    always_comb begin
        case (sub)
            oag_pkg::JC_ALWAYS: taken = 1'b1;
            oag_pkg::JC_NE:     taken = !eq_reg;
            oag_pkg::JC_ODD:    taken = odd_reg;
            oag_pkg::JC_CARRY:  taken = cy_reg;
            default:            taken = 1'b0;
        endcase
    end

    // Result of the executing instruction; bytes sit in bits 15:8.
    always_comb begin
        wide   = 17'h00000;
        res    = dst_reg;
        res_cy = cy_reg;
        if (single) begin
            if (sub == oag_pkg::SUB_DECR) begin
                res    = dst_reg - 16'h0001;
                res_cy = (dst_reg != 16'h0000);
            end else begin
                res = 16'h0000;
            end
        end else if (opc == oag_pkg::OP_ADD) begin
            wide   = {1'b0, dst_reg} + {1'b0, src_reg};
            res    = wide[15:0];
            res_cy = wide[16];
        end else if (opc == oag_pkg::OP_SET_ZEROS) begin
            res = dst_reg & ~src_reg;
        end else if (opc == oag_pkg::OP_SUB_BYTE) begin
            res    = dst_reg - src_reg;
            res_cy = (dst_reg >= src_reg);
        end else if (opc == oag_pkg::OP_MOVE) begin
            res = src_reg;
        end
    end

    // Memory port requests follow the state.
    always_comb begin
        mem_req   = 1'b0;
        mem_we    = 1'b0;
        mem_addr  = {pc_reg[15:1], 1'b0};
        mem_wdata = 16'h0000;
        mem_be    = 2'b11;
        case (state_reg)
            oag_pkg::S_FETCH, oag_pkg::S_EXT: begin
                mem_req = 1'b1;
            end
            oag_pkg::S_REG: begin
                mem_req  = 1'b1;
                mem_addr = reg_addr;
            end
            oag_pkg::S_OPRD, oag_pkg::S_WRITE: begin
                mem_req  = 1'b1;
                mem_we   = (state_reg == oag_pkg::S_WRITE);
                mem_addr = {ea_reg[15:1], 1'b0};
                if (is_byte) begin
                    mem_be    = ea_reg[0] ? 2'b01 : 2'b10;
                    mem_wdata = {res[15:8], res[15:8]};
                end else begin
                    mem_wdata = res;
                end
            end
            oag_pkg::S_INC, oag_pkg::S_DINC: begin
                mem_req   = 1'b1;
                mem_we    = 1'b1;
                mem_addr  = reg_addr;
                mem_wdata = inc_val;
            end
            oag_pkg::S_LINK: begin
                mem_req   = 1'b1;
                mem_we    = 1'b1;
                mem_addr  = {wp_reg[15:1], 1'b0}
                            + oag_pkg::LINK_OFFSET;
                mem_wdata = pc_reg;
            end
            default: begin
                mem_req = 1'b0;
            end
        endcase
    end

    // Sequencer next state.
    always_comb begin
        state_next = state_reg;
        pc_next    = pc_reg;
        wp_next    = wp_set ? wp_data : wp_reg;
        ir_next    = ir_reg;
        ext_next   = ext_reg;
        rv_next    = rv_reg;
        ea_next    = ea_reg;
        src_next   = src_reg;
        dst_next   = dst_reg;
        phase_next = phase_reg;
        eq_next    = eq_reg;
        cy_next    = cy_reg;
        odd_next   = odd_reg;
        case (state_reg)
            oag_pkg::S_FETCH: begin
                if (mem_ack) begin
                    ir_next    = mem_rdata;
                    pc_next    = pc_reg + oag_pkg::WORD_STEP;
                    state_next = oag_pkg::S_DECODE;
                end
            end
            oag_pkg::S_DECODE: begin
                phase_next = single;
                if (opc == oag_pkg::OP_JUMP) begin
                    if (taken) begin
                        pc_next = jtarget;
                    end
                    state_next = oag_pkg::S_FETCH;
                end else if (known) begin
                    state_next = oag_pkg::S_START;
                end else begin
                    state_next = oag_pkg::S_FETCH;
                end
            end
            oag_pkg::S_START: begin
                if (mode == oag_pkg::MODE_SYM) begin
                    state_next = oag_pkg::S_EXT;
                end else if (mode == oag_pkg::MODE_REG) begin
                    state_next = oag_pkg::S_ADDR;
                end else begin
                    state_next = oag_pkg::S_REG;
                end
            end
            oag_pkg::S_EXT: begin
                if (mem_ack) begin
                    ext_next   = mem_rdata;
                    pc_next    = pc_reg + oag_pkg::WORD_STEP;
                    state_next = (rnum != 4'h0) ? oag_pkg::S_REG
                                                : oag_pkg::S_ADDR;
                end
            end
            oag_pkg::S_REG: begin
                if (mem_ack) begin
                    rv_next    = mem_rdata;
                    state_next = oag_pkg::S_ADDR;
                end
            end
            oag_pkg::S_ADDR: begin
                ea_next    = ea_calc;
                state_next = (single && sub == oag_pkg::SUB_LINK)
                             ? oag_pkg::S_LINK : oag_pkg::S_OPRD;
            end
            oag_pkg::S_OPRD: begin
                if (mem_ack) begin
                    if (!phase_reg) begin
                        // Source fields stay selected until INC steps them.
                        src_next   = is_byte ? byte_in : mem_rdata;
                        phase_next = (mode != oag_pkg::MODE_AUTO);
                        state_next = (mode == oag_pkg::MODE_AUTO)
                                     ? oag_pkg::S_INC : oag_pkg::S_START;
                    end else if (opc == oag_pkg::OP_CMP_BYTE) begin
                        eq_next    = (byte_in == src_reg);
                        odd_next   = ^src_reg[15:8];
                        state_next = (mode == oag_pkg::MODE_AUTO)
                                     ? oag_pkg::S_DINC : oag_pkg::S_FETCH;
                    end else begin
                        dst_next   = is_byte ? byte_in : mem_rdata;
                        state_next = oag_pkg::S_WRITE;
                    end
                end
            end
            oag_pkg::S_INC: begin
                if (mem_ack) begin
                    phase_next = 1'b1;
                    state_next = oag_pkg::S_START;
                end
            end
            oag_pkg::S_WRITE: begin
                if (mem_ack) begin
                    eq_next    = is_byte ? (res[15:8] == 8'h00)
                                         : (res == 16'h0000);
                    odd_next   = is_byte ? ^res[15:8] : odd_reg;
                    cy_next    = res_cy;
                    state_next = (mode == oag_pkg::MODE_AUTO)
                                 ? oag_pkg::S_DINC : oag_pkg::S_FETCH;
                end
            end
            oag_pkg::S_LINK: begin
                if (mem_ack) begin
                    pc_next    = ea_reg;
                    state_next = (mode == oag_pkg::MODE_AUTO)
                                 ? oag_pkg::S_DINC : oag_pkg::S_FETCH;
                end
            end
            oag_pkg::S_DINC: begin
                if (mem_ack) begin
                    state_next = oag_pkg::S_FETCH;
                end
            end
            default: begin
                state_next = oag_pkg::S_FETCH;
            end
        endcase
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_reg <= oag_pkg::S_FETCH;
            pc_reg    <= oag_pkg::RESET_PC;
            wp_reg    <= oag_pkg::RESET_WP;
            ir_reg    <= 16'h0000;
            ext_reg   <= 16'h0000;
            rv_reg    <= 16'h0000;
            ea_reg    <= 16'h0000;
            src_reg   <= 16'h0000;
            dst_reg   <= 16'h0000;
            phase_reg <= 1'b0;
            eq_reg    <= 1'b0;
            cy_reg    <= 1'b0;
            odd_reg   <= 1'b0;
        end else begin
            state_reg <= state_next;
            pc_reg    <= pc_next;
            wp_reg    <= wp_next;
            ir_reg    <= ir_next;
            ext_reg   <= ext_next;
            rv_reg    <= rv_next;
            ea_reg    <= ea_next;
            src_reg   <= src_next;
            dst_reg   <= dst_next;
            phase_reg <= phase_next;
            eq_reg    <= eq_next;
            cy_reg    <= cy_next;
            odd_reg   <= odd_next;
        end
    end

    assign pc           = pc_reg;
    assign wp           = wp_reg;
    assign status_eq    = eq_reg;
    assign status_carry = cy_reg;
    assign status_odd   = odd_reg;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    property p_jump_target;
        state_reg == oag_pkg::S_DECODE && opc == oag_pkg::OP_JUMP && taken
        |=> pc_reg == $past(pc_reg) + {{7{$past(ir_reg[7])}},
                                       $past(ir_reg[7:0]), 1'b0};
    endproperty
    a_jump_target: assert property (p_jump_target)
        else $error("jump target wrong");
    property p_jne_fall;
        state_reg == oag_pkg::S_DECODE && opc == oag_pkg::OP_JUMP &&
        sub == oag_pkg::JC_NE && eq_reg |=> pc_reg == $past(pc_reg);
    endproperty
    a_jne_fall: assert property (p_jne_fall)
        else $error("not-equal jump taken with equal set");
    property p_jop_fall;
        state_reg == oag_pkg::S_DECODE && opc == oag_pkg::OP_JUMP &&
        sub == oag_pkg::JC_ODD && !odd_reg |=> pc_reg == $past(pc_reg);
    endproperty
    a_jop_fall: assert property (p_jop_fall)
        else $error("odd parity jump taken with parity clear");
    property p_ext_step;
        state_reg == oag_pkg::S_EXT && mem_ack
        |=> pc_reg == $past(pc_reg) + 16'h0002;
    endproperty
    a_ext_step: assert property (p_ext_step)
        else $error("extension fetch did not advance pc");
    property p_write_then_inc;
        state_reg == oag_pkg::S_WRITE && mem_ack &&
        mode == oag_pkg::MODE_AUTO |=> state_reg == oag_pkg::S_DINC;
    endproperty
    a_write_then_inc: assert property (p_write_then_inc)
        else $error("autoincrement not after destination write");
    property p_link;
        state_reg == oag_pkg::S_LINK |-> mem_we &&
        mem_addr == {wp_reg[15:1], 1'b0} + 16'h0016 && mem_wdata == pc_reg;
    endproperty
    a_link: assert property (p_link)
        else $error("link store wrong");
    property p_word_align;
        mem_req && mem_be == 2'b11 |-> mem_addr[0] == 1'b0;
    endproperty
    a_word_align: assert property (p_word_align)
        else $error("odd word address");
    property p_symbolic;
        state_reg == oag_pkg::S_ADDR && mode == oag_pkg::MODE_SYM &&
        rnum == 4'h0 |=> ea_reg == $past(ext_reg);
    endproperty
    a_symbolic: assert property (p_symbolic)
        else $error("register zero used as index");
    property p_set_zeros;
        state_reg == oag_pkg::S_WRITE && opc == oag_pkg::OP_SET_ZEROS
        |-> mem_wdata == (dst_reg & ~src_reg);
    endproperty
    a_set_zeros: assert property (p_set_zeros)
        else $error("set zeros result wrong");
    property p_src_inc;
        state_reg == oag_pkg::S_INC
        |-> mem_addr == {wp_reg[15:1], 1'b0} + {11'h000, ir_reg[3:0], 1'b0};
    endproperty
    a_src_inc: assert property (p_src_inc)
        else $error("source increment hits wrong register");
    property p_inc;
        state_reg == oag_pkg::S_DINC
        |-> mem_wdata == rv_reg + (is_byte ? 16'h0001 : 16'h0002);
    endproperty
    a_inc: assert property (p_inc)
        else $error("increment amount wrong");
    c_jump: cover property (state_reg == oag_pkg::S_DECODE &&
                            opc == oag_pkg::OP_JUMP && taken);
    c_dinc: cover property (state_reg == oag_pkg::S_DINC && mem_ack);
    c_link: cover property (state_reg == oag_pkg::S_LINK && mem_ack);
    c_byte: cover property (mem_req && mem_we && mem_be != 2'b11);
endmodule

// [test/oag_mem_model.sv]
// Behavioural main memory that answers the core's access port.
`timescale 1ns/10ps
module oag_mem_model (
    input  wire logic        sys_clk,
    input  wire logic        mem_req,
    input  wire logic        mem_we,
    input  wire logic [15:0] mem_addr,
    input  wire logic [15:0] mem_wdata,
    input  wire logic [1:0]  mem_be,
    input  wire logic [1:0]  delay,
    output logic             mem_ack,
    output logic      [15:0] mem_rdata
);
    logic [15:0] mem [0:32767];
    logic [15:0] last_rd;
    logic [1:0]  wait_cnt;

    initial begin
        mem_ack = 1'b0;
        wait_cnt = 2'h0;
        last_rd = 16'h0000;
    end

    // Outside an answered cycle the data lines show the inverse of the last word read.
    assign mem_rdata = mem_ack ? mem[mem_addr[15:1]] : ~last_rd;

    always @(posedge sys_clk) begin
        if (mem_req && mem_ack) begin
            if (mem_we && mem_be[1]) begin
                mem[mem_addr[15:1]][15:8] <= mem_wdata[15:8];
            end
            if (mem_we && mem_be[0]) begin
                mem[mem_addr[15:1]][7:0] <= mem_wdata[7:0];
            end
            last_rd <= mem[mem_addr[15:1]];
            mem_ack <= 1'b0;
            wait_cnt <= 2'h0;
        end else if (mem_req && wait_cnt >= delay) begin
            mem_ack <= 1'b1;
        end else if (mem_req) begin
            wait_cnt <= wait_cnt + 2'h1;
        end
    end
endmodule

// [test/oag_tb_top.sv]
// Self-checking bench running small programs through the address generator.
`timescale 1ns/10ps
module oag_tb_top;
    logic        sys_clk;
    logic        rst;
    logic        wp_set;
    logic [15:0] wp_data;
    logic        mem_req;
    logic        mem_we;
    logic [15:0] mem_addr;
    logic [15:0] mem_wdata;
    logic [1:0]  mem_be;
    logic        mem_ack;
    logic [15:0] mem_rdata;
    logic [15:0] pc;
    logic [15:0] wp;
    logic        status_eq;
    logic        status_carry;
    logic        status_odd;
    logic [1:0]  delay;
    logic [31:0] seed;
    logic [15:0] a, b, d0, d4, d8, da;
    logic [15:0] prog [0:20];
    int          n_mismatch;
    int          checked;

    oag_core i_oag_core (
        .sys_clk(sys_clk), .rst(rst), .wp_set(wp_set), .wp_data(wp_data),
        .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
        .mem_wdata(mem_wdata), .mem_be(mem_be), .mem_ack(mem_ack),
        .mem_rdata(mem_rdata), .pc(pc), .wp(wp), .status_eq(status_eq),
        .status_carry(status_carry), .status_odd(status_odd)
    );

    oag_mem_model i_oag_mem_model (
        .sys_clk(sys_clk), .mem_req(mem_req), .mem_we(mem_we),
        .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_be(mem_be),
        .delay(delay), .mem_ack(mem_ack), .mem_rdata(mem_rdata)
    );

    function automatic logic [31:0] lfsr_next(input logic [31:0] x);
        return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c1_1db7 : 32'h0000_0000);
    endfunction

    function automatic logic [15:0] enc2(input logic [3:0] op,
        input logic [1:0] dm, input logic [3:0] dr,
        input logic [1:0] sm, input logic [3:0] sr);
        return {op, dm, dr, sm, sr};
    endfunction

    // Masked high byte minus the source's high byte; low byte only masked.
    function automatic logic [15:0] exp_sub(input logic [15:0] d,
        input logic [15:0] m, input logic [15:0] s);
        return {(d[15:8] & ~m[15:8]) - s[15:8], d[7:0] & ~m[7:0]};
    endfunction

    function automatic logic [15:0] rd(input logic [15:0] addr);
        return i_oag_mem_model.mem[addr[15:1]];
    endfunction

    task automatic rnd16(output logic [15:0] v);
        seed = lfsr_next(seed);
        v = seed[15:0];
    endtask

    task automatic put(input logic [15:0] addr, input logic [15:0] v);
        i_oag_mem_model.mem[addr[15:1]] = v;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: got %h expected %h",
                     $time, got, exp);
        end
    endtask

    task automatic close_out;
        $display("Counts: %0d checks, %0d mismatches", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic run_test(input int t);
        int n;
        rnd16(a);
        rnd16(b);
        rnd16(d0);
        rnd16(d4);
        rnd16(d8);
        rnd16(da);
        if (t == 0) begin
            a = 16'hffff;
        end
        @(posedge sys_clk);
        rst <= 1'b1;
        delay <= (t == 0) ? 2'h0 : seed[17:16];
        // Indexed, plain symbolic, autoincrement, indirect, byte, loop,
        // parity jumps both ways, move from an autoincremented source,
        // carry jump, then a link into a closed loop at 0040.
        prog = '{enc2(4'h7, 2'h2, 4'h8, 2'h0, 4'h5), 16'h0400,
                 enc2(4'h7, 2'h2, 4'h0, 2'h0, 4'h5), 16'h0400,
                 enc2(4'h7, 2'h3, 4'h7, 2'h0, 4'h5),
                 enc2(4'h4, 2'h1, 4'h7, 2'h0, 4'h3),
                 enc2(4'h5, 2'h3, 4'h7, 2'h0, 4'h5),
                 16'h010f, 16'h11fe,
                 enc2(4'h6, 2'h0, 4'h6, 2'h0, 4'h6), 16'h1201, 16'h020a,
                 enc2(4'h6, 2'h0, 4'h6, 2'h0, 4'hd), 16'h1201, 16'h020c,
                 enc2(4'h8, 2'h2, 4'h0, 2'h3, 4'h4), 16'h0410,
                 16'h1301, 16'h0209, 16'h0020, 16'h0040};
        for (int i = 0; i < 640; i++) begin
            i_oag_mem_model.mem[i] = 16'h0000;
        end
        for (int i = 0; i < 21; i++) begin
            put(16'(2 * i), prog[i]);
        end
        put(16'h0040, 16'h10ff);
        put(16'h010a, a);
        put(16'h0106, b);
        put(16'h010e, 16'h0408);
        put(16'h0110, 16'h0004);
        put(16'h011e, 16'h0002);
        put(16'h010c, 16'h0100);
        put(16'h011a, 16'h0300);
        put(16'h0114, 16'h5a5a);
        put(16'h0118, 16'hffff);
        put(16'h0400, d0);
        put(16'h0404, d4);
        put(16'h0408, d8);
        put(16'h040a, da);
        put(16'h0108, 16'h0402);
        put(16'h0402, b);
        put(16'h0112, 16'h5a5a);
        repeat (6) @(posedge sys_clk);
        chk(pc, oag_pkg::RESET_PC);
        chk(wp, oag_pkg::RESET_WP);
        rst <= 1'b0;
        @(posedge sys_clk);
        wp_set <= 1'b1;
        wp_data <= 16'h0100;
        @(posedge sys_clk);
        wp_set <= 1'b0;
        n = 0;
        while (pc !== 16'h0040 && n < 3000) begin
            @(posedge sys_clk);
            n++;
        end
        @(negedge sys_clk);
        chk(16'(n < 3000), 16'h0001);
        chk(rd(16'h0404), d4 + a);
        chk(rd(16'h0400), d0 + a);
        chk(rd(16'h0408), d8 + a);
        chk(rd(16'h010e), 16'h040b);
        chk(rd(16'h040a), exp_sub(da, b, a));
        chk(rd(16'h010a), a);
        chk(rd(16'h0110), 16'h0004);
        chk(rd(16'h011e), 16'h0000);
        chk(rd(16'h0114), 16'h5a5a);
        chk(rd(16'h0118), 16'h0000);
        chk(rd(16'h0116), 16'h002a);
        chk(rd(16'h0410), b);
        chk(rd(16'h0108), 16'h0404);
        chk(rd(16'h0100), 16'h0000);
        chk(rd(16'h0112), 16'h5a5a);
        chk(16'(status_eq), 16'(b == 16'h0000));
        chk(16'(status_carry), 16'h0001);
        chk(16'(status_odd), 16'h0000);
        chk(wp, 16'h0100);
        $display("Test %0d done, %0d mismatches so far", t, n_mismatch);
    endtask

    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    initial begin
        repeat (40000) @(posedge sys_clk);
        n_mismatch++;
        close_out;
    end

    initial begin
        rst = 1'b1;
        wp_set = 1'b0;
        wp_data = 16'h0000;
        delay = 2'h0;
        seed = 32'h9473;
        n_mismatch = 0;
        checked = 0;
        for (int t = 0; t < 4; t++) begin
            run_test(t);
        end
        close_out;
    end
endmodule
